/* logic/sslb_latch_bank.sv */
/*
 * serial programming port and latch bank of an integer-n synthesizer:
 * three pins shift 24-bit words in, the strobe moves them into latches,
 * plus lock detect counting and the band select clock divider.
 * assumes: serial pins are asynchronous to clock; refTick, fbTick and
 * phaseErrOk come from logic on clock, refTick one pulse per ref cycle.
 */
`timescale 1ns/10ps
`include "sslb_consts.svh"

// What this block does
// - tristate bit at 1 floats charge pump output; 0 means normal pumping
// - polarity bit 1 selects positive detector polarity, 0 negative
// - three-bit monitor select picks the signal driven on monitor pin
// - control DB4 at 1 holds reference and prescaler counters in reset
// - two-bit core current field sets vco core power; host uses 5 mA
// - swallow count is five bits, every value 0 to 31 accepted
// - main count is thirteen bits, valid 3 to 8191, smaller out of range
// - feedback division equals prescaler modulus times main plus swallow
// - divider DB21 picks current setting 2 when 1, setting 1 when 0
// - gain is one bit, last write from control DB10 or divider DB21
// - divider DB22 at 1 enables output halving, 0 gives undivided
// - divider DB23 at 1 feeds halved output to prescaler, else fundamental
// - target bits (0,1) load the reference divider latch
// - reference ratio field is fourteen bits, divide 1 to 16383
// - reference DB17:DB16 select antibacklash pulse width
// - lock after 5 (window bit 1) or 3 good consecutive ref cycles
// - test bit kept 0 by host except one bench write; while 0, test latch contents are ignored
// - band logic clocked by reference output, optional divider reduces it
// - bit shifted per rising serial clock; strobe rise moves 24 bits
// - target bits (0,0) load the control latch
module sslb_latch_bank (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        serialClk,
	input  wire logic        serialData,
	input  wire logic        loadStrobe,
	input  wire logic        refTick,
	input  wire logic        fbTick,
	input  wire logic        phaseErrOk,
	output logic             chargePumpTristate,
	output logic             phasePolarity,
	output logic             monitorOutputPin,
	output logic             counterReset,
	output logic [1:0]       coreCurrentSelect,
	output logic [1:0]       powerDownMode,
	output logic [4:0]       swallowCount,
	output logic [12:0]      mainCount,
	output logic             mainCountInRange,
	output logic [18:0]      feedbackDivide,
	output logic             pumpGain,
	output logic [2:0]       pumpCurrentSetting,
	output logic             outputHalveEn,
	output logic             prescalerHalfSel,
	output logic [13:0]      referenceDivideRatio,
	output logic             refRatioInRange,
	output logic [1:0]       antibacklashWidth,
	output logic             lockWindowSelect,
	output logic             lockDetect,
	output logic             bandSelectTick,
	output logic [3:0]       testModeBits
);
	sslb_pkg::sslb_state_t st, nxt_st;

	logic sclkRise;
	logic leRise;
	logic loadCtrl;
	logic loadDiv;
	logic loadRef;
	logic loadTest;

	// a change counts only once stages two and three agree
	assign sclkRise = (st.sclkSync[2] == st.sclkSync[1]) &&
		st.sclkSync[1] && !st.sclkStable;
	assign leRise = (st.leSync[2] == st.leSync[1]) &&
		st.leSync[1] && !st.leStable;
	assign loadCtrl = leRise && st.shift[1:0] == `SSLB_TGT_CTRL;
	assign loadRef  = leRise && st.shift[1:0] == `SSLB_TGT_REF;
	assign loadDiv  = leRise && st.shift[1:0] == `SSLB_TGT_DIV;
	assign loadTest = leRise && st.shift[1:0] == `SSLB_TGT_TEST;

	always_comb begin
		logic [5:0] presc;
		logic [2:0] lockTarget;
		logic [2:0] bandTop;
		presc = `SSLB_PRE_8;
		lockTarget = `SSLB_LOCK_SHORT;
		bandTop = 3'h0;
		nxt_st = st;
		nxt_st.sclkSync = {st.sclkSync[1:0], serialClk};
		nxt_st.dataSync = {st.dataSync[1:0], serialData};
		nxt_st.leSync   = {st.leSync[1:0], loadStrobe};
		if (st.sclkSync[2] == st.sclkSync[1]) begin
			nxt_st.sclkStable = st.sclkSync[2];
		end
		if (st.dataSync[2] == st.dataSync[1]) begin
			nxt_st.dataStable = st.dataSync[2];
		end
		if (st.leSync[2] == st.leSync[1]) begin
			nxt_st.leStable = st.leSync[2];
		end
		// msb first, so the target bits land in DB1:DB0
		if (sclkRise) begin
			nxt_st.shift = {st.shift[22:0], st.dataStable};
		end
		if (loadCtrl) begin
			nxt_st.ctrlWord = st.shift;
			nxt_st.pumpGain = st.shift[`SSLB_C_GAIN];
		end
		if (loadDiv) begin
			nxt_st.divWord  = st.shift;
			nxt_st.pumpGain = st.shift[`SSLB_D_GAIN];
		end
		if (loadRef) begin
			nxt_st.refWord = st.shift;
		end
		if (loadTest) begin
			nxt_st.testWord = st.shift;
		end
		// test latch only reaches outward while the test bit is set
		if (st.refWord[`SSLB_R_TEST]) begin
			nxt_st.testBits = st.testWord[5:2];
		end else begin
			nxt_st.testBits = 4'h0;
		end
		// registered from the next gain and word, so the pins move together
		if (nxt_st.pumpGain) begin
			nxt_st.curSel = nxt_st.ctrlWord[`SSLB_C_CUR2_LO +: 3];
		end else begin
			nxt_st.curSel = nxt_st.ctrlWord[`SSLB_C_CUR1_LO +: 3];
		end

		case (st.ctrlWord[`SSLB_C_PRE_LO +: 2])
			2'h0:    presc = `SSLB_PRE_8;
			2'h1:    presc = `SSLB_PRE_16;
			default: presc = `SSLB_PRE_32;
		endcase
		// one cycle behind the latch, so an update is never half seen
		nxt_st.fbDivide = 19'(presc) * 19'(st.divWord[`SSLB_D_MAIN_LO +: 13])
			+ 19'(st.divWord[`SSLB_D_SWAL_LO +: 5]);
		nxt_st.mainInRange =
			st.divWord[`SSLB_D_MAIN_LO +: 13] >= `SSLB_MAIN_MIN;
		nxt_st.refInRange =
			st.refWord[`SSLB_R_RATIO_LO +: 14] != 14'h0000;

		if (st.refWord[`SSLB_R_LWIN]) begin
			lockTarget = `SSLB_LOCK_LONG;
		end
		if (st.ctrlWord[`SSLB_C_RESET]) begin
			nxt_st.lockCnt = 3'h0;
			nxt_st.lockDetect = 1'b0;
		end else if (refTick) begin
			if (!phaseErrOk) begin
				nxt_st.lockCnt = 3'h0;
			end else if (st.lockCnt < lockTarget) begin
				nxt_st.lockCnt = st.lockCnt + 3'h1;
			end
		end
		if (!st.ctrlWord[`SSLB_C_RESET]) begin
			nxt_st.lockDetect = nxt_st.lockCnt >= lockTarget;
		end

		// divider 1, 2, 4 or 8 on the reference output
		case (st.refWord[`SSLB_R_BAND_LO +: 2])
			2'h0:    bandTop = 3'h0;
			2'h1:    bandTop = 3'h1;
			2'h2:    bandTop = 3'h3;
			default: bandTop = 3'h7;
		endcase
		nxt_st.bandTick = 1'b0;
		if (st.ctrlWord[`SSLB_C_RESET]) begin
			nxt_st.bandCnt = 3'h0;
		end else if (refTick) begin
			if (st.bandCnt >= bandTop) begin
				nxt_st.bandCnt = 3'h0;
				nxt_st.bandTick = 1'b1;
			end else begin
				nxt_st.bandCnt = st.bandCnt + 3'h1;
			end
		end

		case (st.ctrlWord[`SSLB_C_MON_LO +: 3])
			3'h1:    nxt_st.monitorOut = st.lockDetect;
			3'h2:    nxt_st.monitorOut = fbTick;
			3'h3:    nxt_st.monitorOut = 1'b1;
			3'h4:    nxt_st.monitorOut = refTick;
			3'h6:    nxt_st.monitorOut = st.shift[23];
			default: nxt_st.monitorOut = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= nxt_st;
		end
	end

	assign chargePumpTristate = st.ctrlWord[`SSLB_C_TRI];
	assign phasePolarity = st.ctrlWord[`SSLB_C_POL];
	assign monitorOutputPin = st.monitorOut;
	assign counterReset = st.ctrlWord[`SSLB_C_RESET];
	assign coreCurrentSelect = st.ctrlWord[`SSLB_C_CORE_LO +: 2];
	assign powerDownMode = st.ctrlWord[`SSLB_C_PD_LO +: 2];
	assign swallowCount = st.divWord[`SSLB_D_SWAL_LO +: 5];
	assign mainCount = st.divWord[`SSLB_D_MAIN_LO +: 13];
	assign mainCountInRange = st.mainInRange;
	assign feedbackDivide = st.fbDivide;
	assign pumpGain = st.pumpGain;
	assign pumpCurrentSetting = st.curSel;
	assign outputHalveEn = st.divWord[`SSLB_D_HALVE];
	assign prescalerHalfSel = st.divWord[`SSLB_D_HSEL];
	assign referenceDivideRatio = st.refWord[`SSLB_R_RATIO_LO +: 14];
	assign refRatioInRange = st.refInRange;
	assign antibacklashWidth = st.refWord[`SSLB_R_ABP_LO +: 2];
	assign lockWindowSelect = st.refWord[`SSLB_R_LWIN];
	assign lockDetect = st.lockDetect;
	assign bandSelectTick = st.bandTick;
	assign testModeBits = st.testBits;

	property p_tristate;
		@(posedge clock) disable iff (!nrst)
		loadCtrl |=> chargePumpTristate == $past(st.shift[9]);
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("tristate bit not taken from control word");

	property p_polarity;
		@(posedge clock) disable iff (!nrst)
		loadCtrl |=> phasePolarity == $past(st.shift[8]) && !loadCtrl;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("polarity bit not taken from control word");

	property p_monitor;
		@(posedge clock) disable iff (!nrst)
		(st.ctrlWord[7:5] == 3'h3 && !loadCtrl) |=> ##1 monitorOutputPin;
	endproperty
	a_monitor: assert property (p_monitor)
		else $error("monitor pin not high with select 3");

	property p_counter_reset;
		@(posedge clock) disable iff (!nrst)
		counterReset |=> !lockDetect && st.lockCnt == 3'h0;
	endproperty
	a_counter_reset: assert property (p_counter_reset)
		else $error("lock count runs while counters in reset");

	property p_swallow;
		@(posedge clock) disable iff (!nrst)
		loadDiv |=> swallowCount == $past(st.shift[6:2]);
	endproperty
	a_swallow: assert property (p_swallow)
		else $error("swallow count not loaded from DB6:DB2");

	property p_main_range;
		@(posedge clock) disable iff (!nrst)
		loadDiv ##1 !loadDiv |=>
			mainCountInRange == ($past(st.shift[20:8], 2) >= 13'h0003);
	endproperty
	a_main_range: assert property (p_main_range)
		else $error("main count range flag wrong");

	property p_fb_divide;
		@(posedge clock) disable iff (!nrst)
		(loadDiv && st.ctrlWord[23:22] == 2'h0) ##1 !loadDiv ##1 !loadCtrl
			|-> feedbackDivide == 19'h8 * 19'(mainCount) + 19'(swallowCount);
	endproperty
	a_fb_divide: assert property (p_fb_divide)
		else $error("feedback division not modulus times main plus swallow");

	property p_gain_shared;
		@(posedge clock) disable iff (!nrst)
		(loadCtrl |=> pumpGain == $past(st.shift[10])) and
		(loadDiv |=> pumpGain == $past(st.shift[21]));
	endproperty
	a_gain_shared: assert property (p_gain_shared)
		else $error("gain bit not last written value");

	property p_halve;
		@(posedge clock) disable iff (!nrst)
		loadDiv |=> outputHalveEn == $past(st.shift[22]) &&
			prescalerHalfSel == $past(st.shift[23]);
	endproperty
	a_halve: assert property (p_halve)
		else $error("halving bits not loaded");

	property p_ref_load;
		@(posedge clock) disable iff (!nrst)
		loadRef |=> referenceDivideRatio == $past(st.shift[15:2]) &&
			antibacklashWidth == $past(st.shift[17:16]);
	endproperty
	a_ref_load: assert property (p_ref_load)
		else $error("reference word not loaded for target 01");

	property p_lock_count;
		@(posedge clock) disable iff (!nrst)
		$rose(lockDetect) |->
			st.lockCnt == (lockWindowSelect ? 3'h5 : 3'h3);
	endproperty
	a_lock_count: assert property (p_lock_count)
		else $error("lock declared after wrong cycle count");

	property p_test_ignored;
		@(posedge clock) disable iff (!nrst)
		!st.refWord[19] |=> testModeBits == 4'h0;
	endproperty
	a_test_ignored: assert property (p_test_ignored)
		else $error("test latch leaks with test bit clear");

	property p_shift;
		@(posedge clock) disable iff (!nrst)
		sclkRise |=>
			st.shift == {$past(st.shift[22:0]), $past(st.dataStable)};
	endproperty
	a_shift: assert property (p_shift)
		else $error("serial bit not shifted in on clock rise");

	property p_ctrl_load;
		@(posedge clock) disable iff (!nrst)
		loadCtrl |=> st.ctrlWord == $past(st.shift);
	endproperty
	a_ctrl_load: assert property (p_ctrl_load)
		else $error("control word not loaded for target 00");

	property p_band_after_ref;
		@(posedge clock) disable iff (!nrst)
		bandSelectTick |-> $past(refTick);
	endproperty
	a_band_after_ref: assert property (p_band_after_ref)
		else $error("band tick without reference tick");

	c_lock: cover property (@(posedge clock) disable iff (!nrst)
		$rose(lockDetect));
	c_div: cover property (@(posedge clock) disable iff (!nrst) loadDiv);
	c_ref: cover property (@(posedge clock) disable iff (!nrst) loadRef);
	c_band: cover property (@(posedge clock) disable iff (!nrst)
		bandSelectTick && st.refWord[21:20] == 2'h3);
endmodule // sslb_latch_bank

/* logic/sslb_consts.svh */
/*
 * bit positions, reset values and figures of the serial latch bank.
 * assumes: included by the top module by bare name; the package does not include it.
 */
`ifndef SSLB_CONSTS_SVH
`define SSLB_CONSTS_SVH

`define SSLB_WORD_BITS      24
`define SSLB_SERIAL_MHZ_MAX 20
`define SSLB_CLOCK_MHZ      50

// target select codes in DB1:DB0
`define SSLB_TGT_CTRL       2'h0
`define SSLB_TGT_REF        2'h1
`define SSLB_TGT_DIV        2'h2
`define SSLB_TGT_TEST       2'h3

// control word
`define SSLB_C_CORE_LO      2
`define SSLB_C_RESET        4
`define SSLB_C_MON_LO       5
`define SSLB_C_POL          8
`define SSLB_C_TRI          9
`define SSLB_C_GAIN         10
`define SSLB_C_CUR1_LO      14
`define SSLB_C_CUR2_LO      17
`define SSLB_C_PD_LO        20
`define SSLB_C_PRE_LO       22

// divider word
`define SSLB_D_SWAL_LO      2
`define SSLB_D_MAIN_LO      8
`define SSLB_D_GAIN         21
`define SSLB_D_HALVE        22
`define SSLB_D_HSEL         23

// reference word
`define SSLB_R_RATIO_LO     2
`define SSLB_R_ABP_LO       16
`define SSLB_R_LWIN         18
`define SSLB_R_TEST         19
`define SSLB_R_BAND_LO      20

`define SSLB_MAIN_MIN       13'h0003
`define SSLB_LOCK_LONG      3'h5
`define SSLB_LOCK_SHORT     3'h3
`define SSLB_PRE_8          6'h08
`define SSLB_PRE_16         6'h10
`define SSLB_PRE_32         6'h20
`define SSLB_RESET_WORD     24'h000000

`endif

/* logic/sslb_pkg.sv */
/*
 * types of the serial latch bank: the single state record.
 * assumes: sslb_consts.svh sits in the include path.
 */
package sslb_pkg;
	typedef struct packed {
		logic [2:0]  sclkSync;
		logic [2:0]  dataSync;
		logic [2:0]  leSync;
		logic        sclkStable;
		logic        dataStable;
		logic        leStable;
		logic [23:0] shift;
		logic [23:0] ctrlWord;
		logic [23:0] divWord;
		logic [23:0] refWord;
		logic [23:0] testWord;
		logic        pumpGain;
		logic [2:0]  lockCnt;
		logic        lockDetect;
		logic [2:0]  bandCnt;
		logic        bandTick;
		logic        monitorOut;
		logic        mainInRange;
		logic        refInRange;
		logic [18:0] fbDivide;
		logic [3:0]  testBits;
		logic [2:0]  curSel;
	} sslb_state_t;
endpackage

/* verification/sslb_host_model.sv */
/*
 * host side of the latch bank: drives serial clock, data and load strobe.
 * assumes: clock is the bench clock; the bench calls send_word.
 */
`timescale 1ns/10ps
module sslb_host_model (
	input  wire logic clock,
	output logic      serialClk,
	output logic      serialData,
	output logic      loadStrobe
);
	initial begin
		serialClk = 1'b0;
		serialData = 1'b0;
		loadStrobe = 1'b0;
	end

	task automatic waitc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// hp clocks per serial phase, 4 to 7: 6.25 MHz at most, under 20 MHz
	task automatic send_word(input logic [23:0] w, input int hp);
		for (int i = 23; i >= 0; i--) begin
			serialData = w[i];
			waitc(hp);
			serialClk = 1'b1;
			waitc(hp);
			serialClk = 1'b0;
		end
		// data is released after the word: show the inverse, not the last bit
		serialData = ~w[0];
		waitc(hp);
		loadStrobe = 1'b1;
		waitc(hp);
		loadStrobe = 1'b0;
		waitc(hp);
	endtask
endmodule // sslb_host_model

/* verification/tb_sslb_latch_bank.sv */
/*
 * self-checking bench of the latch bank: random and corner words through
 * the host model, test latch, lock detect and band clock divider.
 * assumes: sslb_host_model compiled first; no other stimulus source.
 */
`timescale 1ns/10ps
module tb_sslb_latch_bank;
	logic        clock, nrst, refTick, fbTick, phaseErrOk;
	logic        serialClk, serialData, loadStrobe;
	logic        chargePumpTristate, phasePolarity, monitorOutputPin;
	logic        counterReset, mainCountInRange, pumpGain, outputHalveEn;
	logic        prescalerHalfSel, refRatioInRange, lockWindowSelect;
	logic        lockDetect, bandSelectTick;
	logic [1:0]  coreCurrentSelect, powerDownMode, antibacklashWidth;
	logic [4:0]  swallowCount;
	logic [12:0] mainCount;
	logic [18:0] feedbackDivide;
	logic [2:0]  pumpCurrentSetting;
	logic [13:0] referenceDivideRatio;
	logic [3:0]  testModeBits;
	logic [23:0] ctl, dv, rf, ts;
	logic        gn;
	logic [31:0] seed = 32'h35;
	logic [12:0] mains [4] = '{13'h0002, 13'h0003, 13'h1fff, 13'h0000};
	int          fails = 0;
	int          checked = 0;
	int          bands = 0;
	int          n;
	int          b0;
	localparam int SettleGap = 2000;

	sslb_latch_bank uut (
		.clock, .nrst, .serialClk, .serialData, .loadStrobe, .refTick,
		.fbTick, .phaseErrOk, .chargePumpTristate, .phasePolarity,
		.monitorOutputPin, .counterReset, .coreCurrentSelect, .powerDownMode,
		.swallowCount, .mainCount, .mainCountInRange, .feedbackDivide,
		.pumpGain, .pumpCurrentSetting, .outputHalveEn, .prescalerHalfSel,
		.referenceDivideRatio, .refRatioInRange, .antibacklashWidth,
		.lockWindowSelect, .lockDetect, .bandSelectTick, .testModeBits
	);
	sslb_host_model host (.clock, .serialClk, .serialData, .loadStrobe);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	function automatic logic [23:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[23:0];
	endfunction

	function automatic logic [18:0] fbexp();
		logic [18:0] p;
		p = (ctl[23:22] == 2'h0) ? 19'h8 : (ctl[23:22] == 2'h1) ? 19'h10 : 19'h20;
		return p * dv[20:8] + 19'(dv[6:2]);
	endfunction

	// fbTick follows the generator state without advancing it
	always @(posedge clock) begin
		#1 fbTick = seed[3];
		if (bandSelectTick === 1'b1) bands++;
	end

	task automatic chk(input logic [18:0] got, input logic [18:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic ck_all();
		chk(referenceDivideRatio, rf[15:2]);
		chk(refRatioInRange, rf[15:2] != 14'h0);
		chk(antibacklashWidth, rf[17:16]);
		chk(lockWindowSelect, rf[18]);
		chk(testModeBits, rf[19] ? ts[5:2] : 4'h0);
		chk(chargePumpTristate, ctl[9]);
		chk(phasePolarity, ctl[8]);
		chk(counterReset, ctl[4]);
		chk(coreCurrentSelect, ctl[3:2]);
		chk(powerDownMode, ctl[21:20]);
		chk(pumpGain, gn);
		chk(pumpCurrentSetting, gn ? ctl[19:17] : ctl[16:14]);
		chk(swallowCount, dv[6:2]);
		chk(mainCount, dv[20:8]);
		chk(mainCountInRange, dv[20:8] >= 13'h0003);
		chk(feedbackDivide, fbexp());
		chk(outputHalveEn, dv[22]);
		chk(prescalerHalfSel, dv[23]);
		if (ctl[7:5] == 3'h3) chk(monitorOutputPin, 1'b1);
		if (ctl[7:5] == 3'h0) chk(monitorOutputPin, 1'b0);
		if (ctl[7:5] == 3'h4) chk(monitorOutputPin, 1'b0);
	endtask

	task automatic wr(input logic [23:0] w);
		host.send_word(w, 4 + int'(rnd() & 24'h3));
		if (w[1:0] == 2'h0) ctl = w;
		if (w[1:0] == 2'h1) rf = w;
		if (w[1:0] == 2'h2) dv = w;
		if (w[1:0] == 2'h3) ts = w;
		if (w[1:0] == 2'h0) gn = w[10];
		if (w[1:0] == 2'h2) gn = w[21];
		ck_all();
		if (ctl[7:5] == 3'h6) chk(monitorOutputPin, w[23]);
	endtask

	// phase error flag is random away from the tick, so only the tick counts
	task automatic tick(input logic ok);
		@(posedge clock);
		#1 refTick = 1'b1;
		phaseErrOk = ok;
		@(posedge clock);
		#1 refTick = 1'b0;
		phaseErrOk = ^rnd();
		repeat (2) @(posedge clock);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#2_000_000;
		fails++;
		tally_and_finish();
	end

	initial begin
		{nrst, refTick, phaseErrOk, gn} = 4'h0;
		{ctl, dv, rf, ts} = 96'h0;
		repeat (6) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clock);
		ck_all();
		// reference, control, divider; a short gap stands for the settle time
		for (int i = 0; i < 90; i++) begin
			if (i % 3 == 0) wr(rnd() & 24'h37fffc | 24'h1);
			if (i % 3 == 1) wr(rnd() & 24'hfffffc);
			if (i == 1) begin
				repeat (SettleGap) @(posedge clock);
				#1;
			end
			if (i % 3 == 2) wr(rnd() & 24'hffff7c | 24'h2);
		end
		for (int k = 0; k < 4; k++) begin
			wr({k[1:0], 20'(rnd()), 2'h0});
			wr({3'(rnd()), mains[k], 1'b0, k[0] ? 5'h1f : 5'h0, 2'h2});
		end
		wr({22'(rnd()), 2'h3});
		wr(rf ^ 24'h080000);
		wr(rf ^ 24'h080000);
		wr(ctl & 24'hffffef);
		for (int k = 0; k < 4; k++) begin
			wr({2'h0, k[1:0], 1'b0, k[0], 16'(rnd()) | 16'h1, 2'h1});
			n = k[0] ? 5 : 3;
			repeat (8) tick(1'b0);
			b0 = bands;
			tick(1'b0);
			repeat (n - 1) tick(1'b1);
			chk(lockDetect, 1'b0);
			tick(1'b1);
			chk(lockDetect, 1'b1);
			repeat (7 - n) tick(1'b1);
			chk(19'(bands - b0), 19'(8 >> k));
			tick(1'b0);
			chk(lockDetect, 1'b0);
		end
		wr(ctl | 24'h000010);
		repeat (6) tick(1'b1);
		chk(lockDetect, 1'b0);
		tally_and_finish();
	end
endmodule // tb_sslb_latch_bank
